// *** inc/ldd_pkg.sv ***
// ldd_pkg: constants for the led display configuration block
// assumes 16-bit command words, upper byte selects the target
package ldd_pkg;
    localparam int LDD_WORD_W = 16;
    // upper nibble: operating mode
    localparam logic [3:0] LDD_MODE_BLANK = 4'h0;
    localparam logic [3:0] LDD_MODE_NORMAL = 4'h1;
    localparam logic [3:0] LDD_MODE_LOAD = 4'h2;
    localparam logic [3:0] LDD_MODE_ALL_ON = 4'h3;
    localparam logic [3:0] LDD_MODE_STANDBY = 4'h4;
    // load register targets, bits 11..8
    localparam logic [3:0] LDD_SEL_DUTY = 4'h0;
    localparam logic [3:0] LDD_SEL_DEC_DIG = 4'h1;
    localparam logic [3:0] LDD_SEL_DATA0 = 4'h2;
    localparam logic [3:0] LDD_SEL_DATA3 = 4'h5;
    // standby sub-commands, bits 3..0
    localparam logic [3:0] LDD_SB_HOLD = 4'h0;
    localparam logic [3:0] LDD_SB_CLEAR = 4'h1;
    // decode field values, bits 7..4; largest digit count, bits 3..0
    localparam logic [3:0] LDD_DEC_OFF = 4'h0;
    localparam logic [3:0] LDD_DEC_ON = 4'h1;
    localparam logic [3:0] LDD_DIG_MAX = 4'h3;
    // initial values
    localparam logic [3:0] LDD_DUTY_INIT = 4'hF;
    localparam logic [1:0] LDD_DIG_INIT = 2'h3;
    localparam logic LDD_DEC_INIT = 1'b1;
    localparam logic [7:0] LDD_DATA_INIT = 8'h00;
    localparam logic [15:0] LDD_WORD_INIT = 16'h0000;
    localparam logic [3:0] LDD_CNT_INIT = 4'h0;
endpackage : ldd_pkg

// *** verilog/ldd_serial_rx.sv ***
// ldd_serial_rx: samples the serial pins and assembles 16-bit command words
// assumes clk_sys is several times faster than the serial clock
`timescale 1ns/1ns
module ldd_serial_rx
    import ldd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_latch,
    output logic cmd_valid_r,
    output logic [15:0] cmd_word_r
);
    logic [2:0] clk_s1_r;
    logic [2:0] clk_s2_r;
    logic clk_d_r;
    logic latch_d_r;
    logic [15:0] shift_r;
    logic clk_rise;
    logic latch_rise;

    ////////////////////////////////////////////////////////////////
    // two-flop synchronisers: index 0 clock, 1 data, 2 latch
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clk_s1_r <= 3'h0;
            clk_s2_r <= 3'h0;
        end else begin
            clk_s1_r <= {ser_latch, ser_data, ser_clk};
            clk_s2_r <= clk_s1_r;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clk_d_r <= 1'b0;
            latch_d_r <= 1'b0;
        end else begin
            clk_d_r <= clk_s2_r[0];
            latch_d_r <= clk_s2_r[2];
        end
    end

    assign clk_rise = clk_s2_r[0] & ~clk_d_r;
    assign latch_rise = clk_s2_r[2] & ~latch_d_r;

    ////////////////////////////////////////////////////////////////
    // msb first; data and clock share the same sync delay so setup is kept
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            shift_r <= LDD_WORD_INIT;
        end else if (clk_rise) begin
            shift_r <= {shift_r[14:0], clk_s2_r[1]};
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cmd_valid_r <= 1'b0;
            cmd_word_r <= LDD_WORD_INIT;
        end else begin
            cmd_valid_r <= latch_rise;
            if (latch_rise) begin
                cmd_word_r <= shift_r;
            end
        end
    end
endmodule : ldd_serial_rx

// *** verilog/ldd_config.sv ***
// ldd_config: command interpreter for duty, digit count and decode settings
// assumes digit_sel comes from the scan logic on clk_sys; serial pins are asynchronous
`timescale 1ns/1ns

module ldd_config
    import ldd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_latch,
    input wire logic [1:0] digit_sel,
    output logic [3:0] duty_r,
    output logic [1:0] digit_count_r,
    output logic decode_en_r,
    output logic standby_r,
    output logic blank_r,
    output logic all_on_r,
    output logic [7:0] segment_direct_r,
    output logic [7:0] decoder_char_r
);
    logic cmd_valid;
    logic [15:0] cmd_word;
    logic is_load;
    logic is_clear;
    logic [3:0] sel;
    logic [7:0] data_r [0:3];
    logic [7:0] cur_data;
    // load strobes: duty, decode/count, and one shared by the four data registers
    logic load_duty;
    logic load_dec_dig;
    logic load_data;
    logic [1:0] data_idx;
    logic [1:0] digit_count_nxt;
    logic decode_en_nxt;

    ldd_serial_rx u_rx (
        .clk_sys(clk_sys),
        .rst(rst),
        .ser_clk(ser_clk),
        .ser_data(ser_data),
        .ser_latch(ser_latch),
        .cmd_valid_r(cmd_valid),
        .cmd_word_r(cmd_word)
    );

    ////////////////////////////////////////////////////////////////
    // command decode
    // a load word names its target in bits 11..8 under the load mode in 15..12
    function automatic logic ldd_loads(input logic [15:0] w, input logic [3:0] target);
        return (w[15:12] == LDD_MODE_LOAD) && (w[11:8] == target);
    endfunction : ldd_loads

    function automatic logic ldd_is_data(input logic [3:0] target);
        return (target >= LDD_SEL_DATA0) && (target <= LDD_SEL_DATA3);
    endfunction : ldd_is_data

    function automatic logic [1:0] ldd_data_index(input logic [3:0] target);
        logic [3:0] offset;
        offset = target - LDD_SEL_DATA0;
        return offset[1:0];
    endfunction : ldd_data_index

    // counts above the widest scan are reserved; the count register is only two bits
    function automatic logic ldd_count_ok(input logic [3:0] n);
        return n <= LDD_DIG_MAX;
    endfunction : ldd_count_ok

    assign sel = cmd_word[11:8];
    assign is_load = cmd_valid && (cmd_word[15:12] == LDD_MODE_LOAD);
    assign is_clear = cmd_valid && (cmd_word[15:12] == LDD_MODE_STANDBY)
        && (cmd_word[3:0] == LDD_SB_CLEAR);
    assign load_duty = cmd_valid && ldd_loads(cmd_word, LDD_SEL_DUTY);
    assign load_dec_dig = cmd_valid && ldd_loads(cmd_word, LDD_SEL_DEC_DIG);
    assign load_data = is_load && ldd_is_data(sel);
    assign data_idx = ldd_data_index(sel);

    ////////////////////////////////////////////////////////////////
    // duty register
    // standby hold leaves it alone; only a load, a standby clear or reset moves it
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            duty_r <= LDD_DUTY_INIT;
        end else if (is_clear) begin
            duty_r <= LDD_DUTY_INIT;
        end else if (load_duty) begin
            duty_r <= cmd_word[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // decode and digit count, written together in one word
    // counts 4..15 are reserved and leave the count as it was
    always_comb begin
        digit_count_nxt = digit_count_r;
        if (ldd_count_ok(cmd_word[3:0])) begin
            digit_count_nxt = cmd_word[1:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            digit_count_r <= LDD_DIG_INIT;
        end else if (is_clear) begin
            digit_count_r <= LDD_DIG_INIT;
        end else if (load_dec_dig) begin
            digit_count_r <= digit_count_nxt;
        end
    end

    // other field values are not defined, so they keep the setting
    always_comb begin
        decode_en_nxt = decode_en_r;
        if (cmd_word[7:4] == LDD_DEC_OFF) begin
            decode_en_nxt = 1'b0;
        end else if (cmd_word[7:4] == LDD_DEC_ON) begin
            decode_en_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            decode_en_r <= LDD_DEC_INIT;
        end else if (is_clear) begin
            decode_en_r <= LDD_DEC_INIT;
        end else if (load_dec_dig) begin
            decode_en_r <= decode_en_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // data registers 0..3
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                data_r[i] <= LDD_DATA_INIT;
            end
        end else if (is_clear) begin
            for (int i = 0; i < 4; i++) begin
                data_r[i] <= LDD_DATA_INIT;
            end
        end else if (load_data) begin
            data_r[data_idx] <= cmd_word[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // operating mode flags; settings registers are untouched here
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            standby_r <= 1'b0;
            blank_r <= 1'b1;
            all_on_r <= 1'b0;
        end else if (cmd_valid) begin
            case (cmd_word[15:12])
                LDD_MODE_BLANK: begin
                    standby_r <= 1'b0;
                    blank_r <= 1'b1;
                    all_on_r <= 1'b0;
                end
                LDD_MODE_NORMAL: begin
                    standby_r <= 1'b0;
                    blank_r <= 1'b0;
                    all_on_r <= 1'b0;
                end
                LDD_MODE_ALL_ON: begin
                    standby_r <= 1'b0;
                    blank_r <= 1'b0;
                    all_on_r <= 1'b1;
                end
                LDD_MODE_STANDBY: begin
                    if (cmd_word[3:0] == LDD_SB_HOLD) begin
                        standby_r <= 1'b1;
                    end else if (cmd_word[3:0] == LDD_SB_CLEAR) begin
                        standby_r <= 1'b0;
                        blank_r <= 1'b1;
                        all_on_r <= 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // segment path: direct drive or hand-off to the character generator
    assign cur_data = data_r[digit_sel];

    // the unused path is held at zero so neither side lights a stale pattern
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            segment_direct_r <= LDD_DATA_INIT;
        end else begin
            segment_direct_r <= decode_en_r ? LDD_DATA_INIT : cur_data;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            decoder_char_r <= LDD_DATA_INIT;
        end else begin
            decoder_char_r <= decode_en_r ? cur_data : LDD_DATA_INIT;
        end
    end
endmodule : ldd_config

// *** tb/ldd_config_assertions.sv ***
// ldd_config_assertions: port-level checks of the configuration block
// assumes only the ldd_config ports are visible; bound at the foot of this file
`timescale 1ns/1ns
module ldd_config_assertions
    import ldd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ser_latch,
    input wire logic [3:0] duty_r,
    input wire logic [1:0] digit_count_r,
    input wire logic decode_en_r,
    input wire logic standby_r,
    input wire logic blank_r,
    input wire logic [7:0] segment_direct_r,
    input wire logic [7:0] decoder_char_r
);
    logic [3:0] lat_cnt_r;
    ////////////////////////////////////////////////////////////
    // saturating age of the last latch, so a stale load never excuses a change
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lat_cnt_r <= 4'hF;
        end else if (ser_latch) begin
            lat_cnt_r <= 4'h0;
        end else if (lat_cnt_r != 4'hF) begin
            lat_cnt_r <= lat_cnt_r + 4'h1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_reset_init_values: assert property (
        $fell(rst) |-> duty_r == LDD_DUTY_INIT && digit_count_r == LDD_DIG_INIT && decode_en_r && !standby_r)
        else $error("settings not at initial values after reset");
    a_duty_hold_idle: assert property (
        $changed(duty_r) |-> lat_cnt_r <= 4'h8) else $error("duty changed without a command");
    a_count_hold_idle: assert property (
        $changed(digit_count_r) |-> lat_cnt_r <= 4'h8) else $error("digit count changed without a command");
    a_decode_hold_idle: assert property (
        $changed(decode_en_r) |-> lat_cnt_r <= 4'h8) else $error("decode changed without a command");
    a_blank_hold_idle: assert property (
        $changed(blank_r) |-> lat_cnt_r <= 4'h8) else $error("blank changed without a command");
    a_standby_keeps_all: assert property (
        $rose(standby_r) |-> $stable(duty_r) && $stable(digit_count_r) && $stable(decode_en_r))
        else $error("standby entry altered a setting");
    a_direct_off_decode: assert property (
        decode_en_r && $past(decode_en_r) |-> segment_direct_r == 8'h00) else $error("direct drive while decoding");
    a_char_off_direct: assert property (
        !decode_en_r && !$past(decode_en_r) |-> decoder_char_r == 8'h00) else $error("decoder fed in pass-through");
    c_standby: cover property ($rose(standby_r));
    c_direct: cover property (!decode_en_r && segment_direct_r != 8'h00);
    c_duty: cover property ($changed(duty_r));
endmodule : ldd_config_assertions
bind ldd_config ldd_config_assertions i_chk (.clk_sys(clk_sys), .rst(rst), .ser_latch(ser_latch), .duty_r(duty_r),
    .digit_count_r(digit_count_r), .decode_en_r(decode_en_r), .standby_r(standby_r), .blank_r(blank_r),
    .segment_direct_r(segment_direct_r), .decoder_char_r(decoder_char_r));

// *** tb/ldd_host_model.sv ***
// ldd_host_model: host side of the serial command link, msb first
// assumes send() is called only after reset is released
`timescale 1ns/1ns
module ldd_host_model (
    input wire logic clk_sys,
    output logic ser_clk,
    output logic ser_data,
    output logic ser_latch
);
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_latch = 1'b0;
    end
    // whole words only: count and decode fields always travel together
    task automatic send(input logic [15:0] w);
        @(posedge clk_sys);
        #1;
        for (int i = 15; i >= 0; i--) begin
            ser_data = w[i];
            #30 ser_clk = 1'b1;
            #60 ser_clk = 1'b0;
            #35;
        end
        // idle line shows the inverse so a stale bit cannot pass as a match
        ser_data = ~ser_data;
        #30 ser_latch = 1'b1;
        #60 ser_latch = 1'b0;
    endtask : send
endmodule : ldd_host_model

// *** tb/ldd_config_tb_top.sv ***
// ldd_config_tb_top: command sequences with expected settings and segment data
// assumes the host model drives the serial pins and the checker is bound
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ldd_config_tb_top
    import ldd_pkg::*;
;
    logic clk_sys, rst, ser_clk, ser_data, ser_latch, decode_en_r, standby_r, blank_r, all_on_r;
    logic [1:0] digit_sel, digit_count_r;
    logic [3:0] duty_r;
    logic [7:0] segment_direct_r, decoder_char_r;
    int err_count = 0;
    int n_tests = 0;
    ldd_host_model i_host (.clk_sys(clk_sys), .ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch));
    ldd_config i_dut (.clk_sys(clk_sys), .rst(rst), .ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch),
        .digit_sel(digit_sel), .duty_r(duty_r), .digit_count_r(digit_count_r), .decode_en_r(decode_en_r),
        .standby_r(standby_r), .blank_r(blank_r), .all_on_r(all_on_r), .segment_direct_r(segment_direct_r),
        .decoder_char_r(decoder_char_r));
    ////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    // eight cycles covers the 4..5 cycle answer with margin
    task automatic wr(input logic [15:0] w);
        i_host.send(w);
        tick(8);
    endtask : wr
    task automatic chk_set(input logic [3:0] d, input logic [1:0] c, input logic e);
        `CHK(duty_r, d)
        `CHK(digit_count_r, c)
        `CHK(decode_en_r, e)
    endtask : chk_set
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // about 35 words of 2.2 us each; generous margin
    initial begin
        #500000;
        err_count++;
        print_verdict();
    end
    initial begin
        rst = 1'b1;
        digit_sel = 2'h0;
        tick(12);
        rst = 1'b0;
        chk_set(4'hF, 2'h3, 1'b1);
        for (int n = 0; n < 16; n++) begin
            wr({8'h20, 4'hA, 4'(n)});
            chk_set(4'(n), 2'h3, 1'b1);
        end
        wr(16'h2075);
        for (int n = 0; n < 4; n++) begin
            wr({8'h21, 4'h0, 4'(n)});
            chk_set(4'h5, 2'(n), 1'b0);
        end
        wr(16'h2117);
        chk_set(4'h5, 2'h3, 1'b1);
        wr(16'h2103);
        wr(16'h22A5);
        wr(16'h253C);
        `CHK(segment_direct_r, 8'hA5)
        `CHK(decoder_char_r, 8'h00)
        digit_sel = 2'h3;
        tick(3);
        `CHK(segment_direct_r, 8'h3C)
        wr(16'h2113);
        `CHK(decoder_char_r, 8'h3C)
        `CHK(segment_direct_r, 8'h00)
        wr(16'h3006);
        `CHK(all_on_r, 1'b1)
        `CHK(blank_r, 1'b0)
        wr(16'h2606);
        wr(16'h1006);
        `CHK(all_on_r, 1'b0)
        chk_set(4'h5, 2'h3, 1'b1);
        wr(16'h2047);
        wr(16'h2101);
        wr(16'h2106);
        chk_set(4'h7, 2'h1, 1'b0);
        wr(16'h4000);
        `CHK(standby_r, 1'b1)
        chk_set(4'h7, 2'h1, 1'b0);
        wr(16'h4001);
        chk_set(4'hF, 2'h3, 1'b1);
        `CHK(standby_r, 1'b0)
        `CHK(blank_r, 1'b1)
        tick(3);
        `CHK(decoder_char_r, 8'h00)
        print_verdict();
    end
endmodule : ldd_config_tb_top
